// ==== logic/rfc_pkg.sv ====
// shared constants, enums and carriers for the resonance filter configuration block
package rfc_pkg;
	localparam int unsigned CLK_HZ       = 125_000_000;
	localparam int unsigned CLK_KHZ      = CLK_HZ / 1000;
	localparam int unsigned TUNE_MAX_MS  = 10_000;
	localparam int unsigned EXCITE_MS    = 3_000;
	localparam int unsigned TUNE_MAX_CYC = CLK_KHZ * TUNE_MAX_MS;
	localparam int unsigned EXCITE_CYC   = CLK_KHZ * EXCITE_MS;
	localparam logic [15:0] RES_MIN_HZ   = 16'h0064;
	localparam logic [15:0] RES_MAX_HZ   = 16'h08CA;
	localparam int unsigned ADDR_W       = 8;
	localparam logic [7:0] OFS_TUNE      = 8'h00;
	localparam logic [7:0] OFS_NOTCH_F   = 8'h04;
	localparam logic [7:0] OFS_NOTCH_S   = 8'h08;
	localparam logic [7:0] OFS_SHAFT     = 8'h0C;
	localparam logic [7:0] OFS_CODE      = 8'h10;
	localparam logic [7:0] OFS_INERTIA   = 8'h14;
	localparam logic [7:0] OFS_STATUS    = 8'h18;
	localparam int unsigned F_MODE       = 0;
	localparam int unsigned F_ACC        = 12;
	localparam int unsigned F_SEL        = 0;
	localparam int unsigned F_SEL2       = 12;
	localparam int unsigned F_N3         = 16;
	localparam int unsigned F_N4         = 17;
	localparam int unsigned F_MOTOR      = 16;
	localparam logic [15:0] NOTCH_F_RST  = 16'h1194;
	localparam logic [15:0] NOTCH_S_RST  = 16'h0000;
	localparam logic [15:0] RATIO_RST    = 16'h000A;
	localparam logic [7:0] MOTOR_RST     = 8'h28;
	localparam int unsigned RATIO_STEP   = 10;
	localparam logic [7:0] CODE_LO_MIN   = 8'h02;
	localparam logic [7:0] CODE_LO_MAX   = 8'h1F;
	localparam logic [7:0] CODE_HI_MIN   = 8'h28;
	localparam logic [7:0] CODE_MAX      = 8'h9F;
	localparam int unsigned SHAFT_NUM_LO = 9000;
	localparam int unsigned SHAFT_NUM_HI = 36000;
	localparam int unsigned SHAFT_HI_OFS = 32;
	localparam logic [1:0] RESP_OKAY     = 2'h0;
	localparam logic [1:0] RESP_SLVERR   = 2'h2;

	typedef enum logic [1:0] {TUNE_OFF = 2'h0, TUNE_AUTO = 2'h1, TUNE_MANUAL = 2'h2} rfc_tune_e;
	typedef enum logic [1:0] {SHAFT_AUTO = 2'h0, SHAFT_MAN = 2'h1, SHAFT_DIS = 2'h2} rfc_shaft_e;
	typedef enum logic [2:0] {SEL_TUNE, SEL_NF, SEL_NS, SEL_SHAFT, SEL_CODE, SEL_INER, SEL_STAT,
		SEL_NONE} rfc_sel_e;

	typedef struct packed {
		logic [1:0] mode;
		logic       accuracy;
		logic [1:0] shaft_sel;
		logic       shaft2_sel;
		logic       notch3_en;
		logic       notch4_en;
	} rfc_cfg_s;
endpackage : rfc_pkg

// ==== logic/rfc_shaft_decode.sv ====
// shaft filter frequency code to notch frequency in hertz
`timescale 1ns/1ps
`default_nettype none
module rfc_shaft_decode
	import rfc_pkg::*;
(
	input  wire logic [7:0]  code,
	output logic      [15:0] freq_hz,
	output logic             code_ok
);
	function automatic logic [15:0] code_to_hz(input logic [7:0] c);
		logic [15:0] r;
		r = 16'h0000;
		if (c >= CODE_LO_MIN && c <= CODE_LO_MAX)
		begin
			r = 16'(SHAFT_NUM_LO / 32'(c));
		end
		else if (c >= CODE_HI_MIN && c <= CODE_MAX)
		begin
			r = 16'(SHAFT_NUM_HI / (32'(c) - SHAFT_HI_OFS));
		end
		return r;
	endfunction : code_to_hz

	// 00, 01, 20..27 and anything past 9F decode to zero, i.e. disabled
	assign freq_hz = code_to_hz(code);
	assign code_ok = (code_to_hz(code) != 16'h0000);
endmodule : rfc_shaft_decode
`default_nettype wire

// ==== logic/rfc_top.sv ====
// resonance filter configuration: adaptive notch tuner and shaft filter control
// Behaviour
// - run ends within 10 s, mode goes manual
// - tuner accepts only 100 Hz to 2.25 kHz
// - no tuning start during quick tuning
// - mode 0 off, 1 auto, 2 manual
// - accuracy 0 standard, 1 high, stronger excitation
// - excitation injected for seconds during run
// - shaft select 0 auto, 1 manual, 2 off
// - second shaft select 0 off, 1 auto
// - auto shaft code from motor and inertia
// - manual shaft code kept as written
// - codes 00, 01, 20-27 and anything past 9F disable shaft filter
// - other codes map to tabulated frequency
// - notch 4 enabled blocks shaft filter
// - notch 3 enabled blocks second shaft filter
//
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module rfc_top
	import rfc_pkg::*;
#(
	parameter int unsigned OBSERVE_CYC = TUNE_MAX_CYC,
	parameter int unsigned EXCITE_LEN  = EXCITE_CYC
)(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	output logic      [1:0]        s_axi_bresp,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic      [31:0]       s_axi_rdata,
	output logic      [1:0]        s_axi_rresp,
	input  wire logic              quick_tune_active,
	input  wire logic              res_valid,
	input  wire logic [15:0]       res_hz,
	input  wire logic [15:0]       res_shape,
	output logic                   excite_en,
	output logic                   excite_strong,
	output logic      [15:0]       notch1_freq,
	output logic      [15:0]       notch1_shape,
	output logic                   shaft_filt_en,
	output logic      [15:0]       shaft_filt_hz,
	output logic                   shaft2_filt_en,
	output logic                   tuning_busy
);
	typedef enum {ST_IDLE, ST_RUN} rfc_state_e;

	function automatic rfc_sel_e reg_sel(input logic [ADDR_W-1:0] a);
		case (a)
			OFS_TUNE:    return SEL_TUNE;
			OFS_NOTCH_F: return SEL_NF;
			OFS_NOTCH_S: return SEL_NS;
			OFS_SHAFT:   return SEL_SHAFT;
			OFS_CODE:    return SEL_CODE;
			OFS_INERTIA: return SEL_INER;
			OFS_STATUS:  return SEL_STAT;
			default:     return SEL_NONE;
		endcase
	endfunction : reg_sel

	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (st[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		end
		return r;
	endfunction : wmerge

	rfc_cfg_s          cfg_reg;
	rfc_state_e        state_reg;
	logic [31:0]       tmr_reg;
	logic              quick_meta_reg;
	logic              quick_sync_reg;
	logic              aw_full_reg;
	logic              w_full_reg;
	logic [ADDR_W-1:0] aw_addr_reg;
	logic [31:0]       w_data_reg;
	logic [3:0]        w_strb_reg;
	logic              awready_reg;
	logic              wready_reg;
	logic              bvalid_reg;
	logic [1:0]        bresp_reg;
	logic              arready_reg;
	logic              rvalid_reg;
	logic [31:0]       rdata_reg;
	logic [1:0]        rresp_reg;
	logic [15:0]       notch_f_reg;
	logic [15:0]       notch_s_reg;
	logic [7:0]        code_reg;
	logic [15:0]       ratio_reg;
	logic [7:0]        motor_reg;
	logic              found_reg;
	logic              excite_reg;
	logic              strong_reg;
	logic              shaft_en_reg;
	logic [15:0]       shaft_hz_reg;
	logic              shaft2_en_reg;
	logic              busy_reg;

	logic              aw_hs;
	logic              w_hs;
	logic              ar_hs;
	logic              wr_do;
	logic              aw_full_next;
	logic              w_full_next;
	logic              bvalid_next;
	logic              rvalid_next;
	rfc_sel_e          wsel;
	logic [31:0]       tune_img;
	logic [31:0]       shaft_img;
	logic [31:0]       iner_img;
	logic [31:0]       stat_img;
	logic [31:0]       rd_img;
	logic [31:0]       tune_new;
	logic [31:0]       shaft_new;
	logic [31:0]       iner_new;
	logic [31:0]       nf_new;
	logic [31:0]       ns_new;
	logic [31:0]       code_new;
	logic              tune_start;
	logic              res_hit;
	logic              tune_end;
	logic [16:0]       code_sum;
	logic [7:0]        auto_code;
	logic [15:0]       dec_hz;
	logic              dec_ok;

	// quick tuning flag comes from another unit's domain
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			quick_meta_reg <= 1'b0;
			quick_sync_reg <= 1'b0;
		end
		else
		begin
			quick_meta_reg <= quick_tune_active;
			quick_sync_reg <= quick_meta_reg;
		end
	end

	// bus write side: address and data may arrive in either order
	assign aw_hs        = s_axi_awvalid && awready_reg;
	assign w_hs         = s_axi_wvalid && wready_reg;
	assign wr_do        = aw_full_reg && w_full_reg && !bvalid_reg;
	assign aw_full_next = (aw_full_reg || aw_hs) && !wr_do;
	assign w_full_next  = (w_full_reg || w_hs) && !wr_do;
	assign bvalid_next  = (bvalid_reg && !s_axi_bready) || wr_do;
	assign wsel         = reg_sel(aw_addr_reg);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_full_reg <= 1'b0;
			w_full_reg  <= 1'b0;
			awready_reg <= 1'b1;
			wready_reg  <= 1'b1;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= RESP_OKAY;
			aw_addr_reg <= '0;
			w_data_reg  <= 32'h0000_0000;
			w_strb_reg  <= 4'h0;
		end
		else
		begin
			aw_full_reg <= aw_full_next;
			w_full_reg  <= w_full_next;
			awready_reg <= !aw_full_next && !bvalid_next;
			wready_reg  <= !w_full_next && !bvalid_next;
			bvalid_reg  <= bvalid_next;
			if (aw_hs)
				aw_addr_reg <= s_axi_awaddr;
			if (w_hs)
			begin
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_do)
				bresp_reg <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end
	end

	// register images, shared by read path and strobe merge
	always_comb
	begin
		tune_img                   = 32'h0000_0000;
		tune_img[F_MODE +: 2]      = cfg_reg.mode;
		tune_img[F_ACC]            = cfg_reg.accuracy;
		shaft_img                  = 32'h0000_0000;
		shaft_img[F_SEL +: 2]      = cfg_reg.shaft_sel;
		shaft_img[F_SEL2]          = cfg_reg.shaft2_sel;
		shaft_img[F_N3]            = cfg_reg.notch3_en;
		shaft_img[F_N4]            = cfg_reg.notch4_en;
		iner_img                   = {8'h00, motor_reg, ratio_reg};
		stat_img                   = {shaft_hz_reg, 10'h000, found_reg, quick_sync_reg,
			shaft2_en_reg, shaft_en_reg, excite_reg, busy_reg};
		tune_new                   = wmerge(tune_img, w_data_reg, w_strb_reg);
		shaft_new                  = wmerge(shaft_img, w_data_reg, w_strb_reg);
		iner_new                   = wmerge(iner_img, w_data_reg, w_strb_reg);
		nf_new                     = wmerge({16'h0000, notch_f_reg}, w_data_reg, w_strb_reg);
		ns_new                     = wmerge({16'h0000, notch_s_reg}, w_data_reg, w_strb_reg);
		code_new                   = wmerge({24'h000000, code_reg}, w_data_reg, w_strb_reg);
		case (reg_sel(s_axi_araddr))
			SEL_TUNE:  rd_img = tune_img;
			SEL_NF:    rd_img = {16'h0000, notch_f_reg};
			SEL_NS:    rd_img = {16'h0000, notch_s_reg};
			SEL_SHAFT: rd_img = shaft_img;
			SEL_CODE:  rd_img = {24'h000000, code_reg};
			SEL_INER:  rd_img = iner_img;
			SEL_STAT:  rd_img = stat_img;
			default:   rd_img = 32'h0000_0000;
		endcase
	end

	// bus read side, one read in flight
	assign ar_hs       = s_axi_arvalid && arready_reg;
	assign rvalid_next = (rvalid_reg && !s_axi_rready) || ar_hs;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h0000_0000;
			rresp_reg   <= RESP_OKAY;
		end
		else
		begin
			arready_reg <= !rvalid_next;
			rvalid_reg  <= rvalid_next;
			if (ar_hs)
			begin
				rdata_reg <= rd_img;
				rresp_reg <= (reg_sel(s_axi_araddr) == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
			end
		end
	end

	// writing auto mode starts a run unless quick tuning holds the drive
	assign tune_start = wr_do && wsel == SEL_TUNE && tune_new[F_MODE +: 2] == TUNE_AUTO
		&& state_reg == ST_IDLE && !quick_sync_reg;
	assign res_hit    = state_reg == ST_RUN && cfg_reg.mode == TUNE_AUTO && res_valid
		&& res_hz >= RES_MIN_HZ && res_hz <= RES_MAX_HZ;
	assign tune_end   = state_reg == ST_RUN && (res_hit || tmr_reg == OBSERVE_CYC - 1);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_reg <= ST_IDLE;
			tmr_reg   <= 32'h0000_0000;
			found_reg <= 1'b0;
		end
		else
		begin
			case (state_reg)
				ST_IDLE:
				begin
					tmr_reg <= 32'h0000_0000;
					if (tune_start)
						state_reg <= ST_RUN;
				end
				ST_RUN:
				begin
					// cleared on leaving so the count never reaches the limit
					if (tune_end || cfg_reg.mode != TUNE_AUTO)
					begin
						state_reg <= ST_IDLE;
						tmr_reg   <= 32'h0000_0000;
					end
					else
						tmr_reg <= tmr_reg + 32'h0000_0001;
				end
				default: state_reg <= ST_IDLE;
			endcase
			if (tune_start)
				found_reg <= 1'b0;
			else if (res_hit)
				found_reg <= 1'b1;
		end
	end

	// configuration fields; end of run forces manual and wins over a bus write
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cfg_reg <= '{mode: TUNE_OFF, accuracy: 1'b0, shaft_sel: SHAFT_AUTO,
				shaft2_sel: 1'b1, notch3_en: 1'b0, notch4_en: 1'b0};
			ratio_reg <= RATIO_RST;
			motor_reg <= MOTOR_RST;
		end
		else
		begin
			if (wr_do && wsel == SEL_TUNE)
			begin
				if (!(tune_new[F_MODE +: 2] == TUNE_AUTO && (quick_sync_reg || busy_reg)))
					cfg_reg.mode <= tune_new[F_MODE +: 2];
				cfg_reg.accuracy <= tune_new[F_ACC];
			end
			if (tune_end)
				cfg_reg.mode <= TUNE_MANUAL;
			if (wr_do && wsel == SEL_SHAFT)
			begin
				cfg_reg.shaft_sel  <= shaft_new[F_SEL +: 2];
				cfg_reg.shaft2_sel <= shaft_new[F_SEL2];
				cfg_reg.notch3_en  <= shaft_new[F_N3];
				cfg_reg.notch4_en  <= shaft_new[F_N4];
			end
			if (wr_do && wsel == SEL_INER)
			begin
				ratio_reg <= iner_new[15:0];
				motor_reg <= iner_new[F_MOTOR +: 8];
			end
		end
	end

	// notch 1 settings: tuner writes only in auto, user writes otherwise
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			notch_f_reg <= NOTCH_F_RST;
			notch_s_reg <= NOTCH_S_RST;
		end
		else if (res_hit)
		begin
			notch_f_reg <= res_hz;
			notch_s_reg <= res_shape;
		end
		else if (wr_do && cfg_reg.mode != TUNE_AUTO)
		begin
			if (wsel == SEL_NF)
				notch_f_reg <= nf_new[15:0];
			if (wsel == SEL_NS)
				notch_s_reg <= ns_new[15:0];
		end
	end

	// heavier load pushes the code toward lower frequency
	assign code_sum  = 17'(ratio_reg / RATIO_STEP) + 17'(motor_reg);
	assign auto_code = (code_sum < 17'(CODE_HI_MIN)) ? CODE_HI_MIN :
		(code_sum > 17'(CODE_MAX)) ? CODE_MAX : code_sum[7:0];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			code_reg <= MOTOR_RST;
		else if (cfg_reg.shaft_sel == SHAFT_AUTO)
			code_reg <= auto_code;
		else if (wr_do && wsel == SEL_CODE)
			code_reg <= code_new[7:0];
	end

	rfc_shaft_decode u_decode (
		.code    (code_reg),
		.freq_hz (dec_hz),
		.code_ok (dec_ok)
	);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			excite_reg    <= 1'b0;
			strong_reg    <= 1'b0;
			shaft_en_reg  <= 1'b0;
			shaft_hz_reg  <= 16'h0000;
			shaft2_en_reg <= 1'b0;
			busy_reg      <= 1'b0;
		end
		else
		begin
			busy_reg      <= (state_reg == ST_RUN && !tune_end && cfg_reg.mode == TUNE_AUTO)
				|| tune_start;
			excite_reg    <= (state_reg == ST_RUN && !tune_end && cfg_reg.mode == TUNE_AUTO
				&& tmr_reg < EXCITE_LEN - 1) || tune_start;
			strong_reg    <= cfg_reg.accuracy;
			shaft_en_reg  <= cfg_reg.shaft_sel != SHAFT_DIS && dec_ok
				&& !cfg_reg.notch4_en;
			shaft_hz_reg  <= dec_hz;
			shaft2_en_reg <= cfg_reg.shaft2_sel && !cfg_reg.notch3_en;
		end
	end

	assign s_axi_awready  = awready_reg;
	assign s_axi_wready   = wready_reg;
	assign s_axi_bvalid   = bvalid_reg;
	assign s_axi_bresp    = bresp_reg;
	assign s_axi_arready  = arready_reg;
	assign s_axi_rvalid   = rvalid_reg;
	assign s_axi_rdata    = rdata_reg;
	assign s_axi_rresp    = rresp_reg;
	assign excite_en      = excite_reg;
	assign excite_strong  = strong_reg;
	assign notch1_freq    = notch_f_reg;
	assign notch1_shape   = notch_s_reg;
	assign shaft_filt_en  = shaft_en_reg;
	assign shaft_filt_hz  = shaft_hz_reg;
	assign shaft2_filt_en = shaft2_en_reg;
	assign tuning_busy    = busy_reg;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_run_bounded: assert property (tmr_reg < OBSERVE_CYC)
		else $error("tuning run exceeded observation limit");
	a_end_manual: assert property (tune_end |=> cfg_reg.mode == TUNE_MANUAL && !busy_reg)
		else $error("run end did not switch mode to manual");
	a_range_gate: assert property ($changed(notch_f_reg) && $past(state_reg == ST_RUN)
		|-> notch_f_reg >= RES_MIN_HZ && notch_f_reg <= RES_MAX_HZ)
		else $error("tuner wrote notch outside supported range");
	a_quick_block: assert property (quick_sync_reg && state_reg == ST_IDLE
		|=> !busy_reg)
		else $error("tuning started during quick tuning");
	a_excite_run: assert property (excite_en |-> tuning_busy)
		else $error("excitation outside a tuning run");
	a_strong_acc: assert property (excite_strong == $past(cfg_reg.accuracy))
		else $error("excitation strength not following accuracy");
	a_notch_keep: assert property (cfg_reg.mode == TUNE_MANUAL && !wr_do
		|=> $stable(notch_f_reg) && $stable(notch_s_reg))
		else $error("notch settings changed in manual mode");
	a_code_auto: assert property (cfg_reg.shaft_sel == SHAFT_AUTO && $stable(ratio_reg)
		&& $stable(motor_reg) |=> code_reg == $past(auto_code))
		else $error("auto shaft code not derived");
	a_code_manual: assert property (cfg_reg.shaft_sel == SHAFT_MAN
		&& !(wr_do && wsel == SEL_CODE) |=> $stable(code_reg))
		else $error("manual shaft code overwritten");
	a_shaft_lock: assert property (cfg_reg.notch4_en || !dec_ok |=> !shaft_filt_en)
		else $error("shaft filter active while blocked");
	a_shaft2_lock: assert property (cfg_reg.notch3_en |=> !shaft2_filt_en)
		else $error("second shaft filter active while notch 3 on");

	c_tune_hit: cover property (res_hit ##1 cfg_reg.mode == TUNE_MANUAL);
	c_tune_timeout: cover property (tune_end && !res_hit);
	c_quick_refuse: cover property (wr_do && wsel == SEL_TUNE && quick_sync_reg);
	c_shaft_manual: cover property (cfg_reg.shaft_sel == SHAFT_MAN && shaft_filt_en);
endmodule : rfc_top
`default_nettype wire

// ==== test/resonance_filter_config_tb_top.sv ====
// self-checking bench for the resonance filter configuration block
`timescale 1ns/1ps
`default_nettype none
module resonance_filter_config_tb_top
	import rfc_pkg::*;
;
	localparam int OBS = 200;
	localparam int EXC = 50;
	logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, quick = 1'b0, arm = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, res_valid, excite_en, excite_strong;
	logic shaft_en, shaft2_en, busy;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00, dly = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rd;
	logic [1:0]  bresp, rresp, rsp;
	logic [15:0] res_hz, res_shape, n_f, n_s, s_hz, hz_cmd = 16'h0, sh_cmd = 16'h0;
	int failures = 0, checked = 0, bc, ec, c;
	int codes[11] = '{0, 1, 2, 4, 31, 32, 39, 40, 43, 159, 160};
	always #4 aclk = ~aclk;
	rfc_top #(.OBSERVE_CYC(OBS), .EXCITE_LEN(EXC)) dut_u (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .quick_tune_active(quick),
		.res_valid(res_valid), .res_hz(res_hz), .res_shape(res_shape), .excite_en(excite_en),
		.excite_strong(excite_strong), .notch1_freq(n_f), .notch1_shape(n_s),
		.shaft_filt_en(shaft_en), .shaft_filt_hz(s_hz), .shaft2_filt_en(shaft2_en),
		.tuning_busy(busy));
	rfc_load_model load_u (.aclk(aclk), .aresetn(aresetn), .excite_en(excite_en), .arm(arm),
		.hz_cmd(hz_cmd), .shape_cmd(sh_cmd), .delay_cmd(dly), .res_valid(res_valid),
		.res_hz(res_hz), .res_shape(res_shape));
	task automatic end_of_test();
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic hang();
		failures++;
		$display("mismatch at %0t: wait ran out", $time);
		end_of_test();
	endtask : hang
	// tables of the shaft code: 9000/code low band, 36000/(code-32) high band
	function automatic int exp_hz(input int k);
		if (k >= 2 && k <= 31)
			return 9000 / k;
		if (k >= 40 && k <= 159)
			return 36000 / (k - 32);
		return 0;
	endfunction : exp_hz
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		awaddr  <= a;
		wdata   <= d;
		bready  <= 1'b1;
		for (int i = 0; i <= 1000; i++)
		begin
			if (i == 1000)
				hang();
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid && bready)
			begin
				rsp = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask : wr
	task automatic rdr(input logic [7:0] a);
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr  <= a;
		rready  <= 1'b1;
		for (int i = 0; i <= 1000; i++)
		begin
			if (i == 1000)
				hang();
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid && rready)
			begin
				rd = rdata;
				rsp = rresp;
				rready <= 1'b0;
				break;
			end
		end
	endtask : rdr
	task automatic idle(input int n);
		repeat (n) @(posedge aclk);
	endtask : idle
	task automatic shaft_chk(input int k, input logic sel_off, input logic n4);
		chk({16'h0, s_hz}, exp_hz(k));
		chk({31'h0, shaft_en}, !sel_off && !n4 && exp_hz(k) != 0);
	endtask : shaft_chk
	task automatic run_wait();
		bc = 0;
		ec = 0;
		for (int i = 0; i <= 1000; i++)
		begin
			if (i == 1000)
				hang();
			@(posedge aclk);
			if (!busy)
				break;
			bc++;
			ec += excite_en;
		end
	endtask : run_wait
	initial
	begin
		void'($urandom(32'h0004));
		idle(6);
		aresetn <= 1'b1;
		chk({16'h0, n_f}, NOTCH_F_RST);
		idle(2);
		shaft_chk(40, 1'b0, 1'b0);
		chk({31'h0, shaft2_en}, 1);
		// manual shaft codes: boundaries and random picks
		wr(OFS_SHAFT, 32'h0000_1001);
		for (int j = 0; j < 17; j++)
		begin
			c = (j < 11) ? codes[j] : int'($urandom % 160);
			wr(OFS_CODE, c);
			idle(2);
			shaft_chk(c, 1'b0, 1'b0);
			rdr(OFS_CODE);
			chk(rd, c);
		end
		wr(OFS_SHAFT, 32'h0002_1001);
		idle(2);
		shaft_chk(c, 1'b0, 1'b1);
		wr(OFS_SHAFT, 32'h0001_1001);
		idle(2);
		chk({31'h0, shaft2_en}, 0);
		wr(OFS_SHAFT, 32'h0000_0002);
		idle(2);
		shaft_chk(c, 1'b1, 1'b0);
		chk({31'h0, shaft2_en}, 0);
		// automatic code from motor base and inertia, then clamped at the top
		wr(OFS_SHAFT, 32'h0000_1000);
		wr(OFS_INERTIA, 32'h0030_0032);
		idle(3);
		shaft_chk(53, 1'b0, 1'b0);
		wr(OFS_CODE, 32'h50);
		rdr(OFS_CODE);
		chk(rd, 53);
		wr(OFS_INERTIA, 32'h0090_00C8);
		idle(3);
		shaft_chk(159, 1'b0, 1'b0);
		// tuning run with an in-range hit and high accuracy
		hz_cmd <= 16'd500;
		sh_cmd <= 16'h0015;
		dly <= 8'd10;
		arm <= 1'b1;
		@(posedge aclk);
		arm <= 1'b0;
		wr(OFS_TUNE, 32'h0000_1001);
		idle(1);
		chk({29'h0, busy, excite_en, excite_strong}, 7);
		run_wait();
		chk({n_s, n_f}, {16'h0015, 16'd500});
		rdr(OFS_TUNE);
		chk(rd, 32'h0000_1002);
		// out-of-range resonance is ignored, run ends on its own limit
		hz_cmd <= 16'd50;
		arm <= 1'b1;
		@(posedge aclk);
		arm <= 1'b0;
		wr(OFS_TUNE, 32'h0000_0001);
		run_wait();
		chk(bc >= OBS - 2 && bc <= OBS + 1, 1);
		chk(ec >= EXC - 2 && ec <= EXC + 1, 1);
		chk({16'h0, n_f}, 500);
		rdr(OFS_TUNE);
		chk(rd, 32'h2);
		// quick tuning holds off a new run
		quick <= 1'b1;
		idle(4);
		wr(OFS_TUNE, 32'h1);
		idle(2);
		chk({31'h0, busy}, 0);
		rdr(OFS_TUNE);
		chk(rd, 32'h2);
		quick <= 1'b0;
		wr(OFS_TUNE, 32'h0);
		wr(OFS_NOTCH_F, 32'h384);
		chk({30'h0, rsp}, RESP_OKAY);
		wr(8'h1C, 32'h1);
		chk({30'h0, rsp}, RESP_SLVERR);
		idle(2);
		chk({16'h0, n_f}, 32'h384);
		rdr(8'h1C);
		chk({30'h0, rsp}, RESP_SLVERR);
		chk(rd, 32'h0);
		end_of_test();
	end
endmodule : resonance_filter_config_tb_top
`default_nettype wire

// ==== test/rfc_load_model.sv ====
// behavioural servo motor and load: answers excitation with one resonance pulse
`timescale 1ns/1ps
`default_nettype none
module rfc_load_model
	import rfc_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        excite_en,
	input  wire logic        arm,
	input  wire logic [15:0] hz_cmd,
	input  wire logic [15:0] shape_cmd,
	input  wire logic [7:0]  delay_cmd,
	output logic             res_valid,
	output logic      [15:0] res_hz,
	output logic      [15:0] res_shape
);
	logic       armed_reg;
	logic [7:0] wait_reg;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			armed_reg <= 1'b0;
			wait_reg  <= 8'h00;
			res_valid <= 1'b0;
			res_hz    <= 16'h0000;
			res_shape <= 16'h0000;
		end
		else
		begin
			res_valid <= 1'b0;
			// idle data toggles so a stale value never looks valid
			res_hz    <= ~res_hz;
			res_shape <= ~res_shape;
			if (arm)
			begin
				armed_reg <= 1'b1;
				wait_reg  <= delay_cmd;
			end
			else if (armed_reg && excite_en)
			begin
				if (wait_reg == 8'h00)
				begin
					res_valid <= 1'b1;
					res_hz    <= hz_cmd;
					res_shape <= shape_cmd;
					armed_reg <= 1'b0;
				end
				else
					wait_reg <= wait_reg - 8'h01;
			end
		end
	end
endmodule : rfc_load_model
`default_nettype wire
